/* File: mem_host_pkg.sv */
// package: memory map, host registers, commands and state types for the core
package mem_host_pkg;

  // host register indices on the software port
  localparam logic [3:0] REG_CMD     = 4'h0;
  localparam logic [3:0] REG_ADDR_L  = 4'h1;
  localparam logic [3:0] REG_ADDR_M  = 4'h2;
  localparam logic [3:0] REG_ADDR_H  = 4'h3;
  localparam logic [3:0] REG_WDATA   = 4'h4;
  localparam logic [3:0] REG_CFG     = 4'h5;
  localparam logic [3:0] REG_STATUS  = 4'h6;
  localparam logic [3:0] REG_RDATA_L = 4'h7;
  localparam logic [3:0] REG_RDATA_M = 4'h8;
  localparam logic [3:0] REG_RDATA_H = 4'h9;

  // configuration bits
  localparam int CFG_SWAP_BIT      = 0;
  localparam int CFG_SELFPROG_BIT  = 1;
  localparam int CFG_LARGE_RAM_BIT = 2;
  localparam logic [2:0] CFG_RESET = 3'h0;

  // status bits
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_DONE_BIT    = 1;
  localparam int ST_REFUSED_BIT = 2;
  localparam int ST_GUARD_BIT   = 3;

  // fixed low code flash tables
  localparam logic [19:0] VEC_BASE    = 20'h00000;
  localparam logic [19:0] SWAP_OFFSET = 20'h01000;
  localparam logic [19:0] TCALL_BASE  = 20'h00080;
  localparam logic [19:0] OPT_BASE    = 20'h000C0;
  localparam logic [19:0] SECID_BASE  = 20'h000C4;
  localparam logic [3:0]  SECID_LEN   = 4'hA;

  // upper window: mirror, extended peripherals, ram, peripherals
  localparam logic [19:0] MIRROR_LO     = 20'hF0000;
  localparam logic [19:0] EXT_PERIPH_HI = 20'hF07FF;
  localparam logic [19:0] RAM_LO_SMALL  = 20'hFF700;
  localparam logic [19:0] RAM_LO_LARGE  = 20'hFEF00;
  localparam logic [19:0] RAM_HI        = 20'hFFEFF;
  localparam logic [19:0] GPR_LO        = 20'hFFEE0;
  localparam logic [19:0] SELFPROG_LO   = 20'hFFE20;
  localparam logic [19:0] SELFPROG_HI   = 20'hFFEDF;
  localparam logic [19:0] LIB_LO        = 20'hFEF00;
  localparam logic [19:0] LIB_HI        = 20'hFF309;
  localparam logic [19:0] PERIPH_LO     = 20'hFFF00;

  // flash mirror control register in the device
  localparam logic [19:0] MIRROR_CTRL_ADDR  = 20'hFFFFE;
  localparam logic [7:0]  MIRROR_CTRL_RESET = 8'h00;
  localparam int          MIRROR_SELECT_BIT = 0;

  // cycles held off the mirror after its control register is written
  localparam logic [3:0] MIRROR_GUARD_CYCLES = 4'h2;

  typedef enum logic [2:0] {
    CMD_READ         = 3'b000,
    CMD_WRITE        = 3'b001,
    CMD_FETCH        = 3'b010,
    CMD_VECTOR       = 3'b011,
    CMD_TABLE_CALL   = 3'b100,
    CMD_RESET_VECTOR = 3'b101,
    CMD_OPTION       = 3'b110,
    CMD_SECID        = 3'b111
  } cmd_t;

  typedef enum logic [2:0] {
    S_IDLE      = 3'b000,
    S_CHECK     = 3'b001,
    S_STROBE_LO = 3'b010,
    S_CAP_LO    = 3'b011,
    S_STROBE_HI = 3'b100,
    S_CAP_HI    = 3'b101
  } fsm_t;

  // one access toward the device
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
    logic        fetch;
  } mem_req_t;

  typedef struct packed {
    fsm_t        fsm;
    cmd_t        cmd;
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic [2:0]  cfg;
    logic        done;
    logic        refused;
    logic [3:0]  guard;
    logic [19:0] result;
    logic [7:0]  sw_rdata;
    mem_req_t    req;
  } state_t;

endpackage

/* File: mem_host.sv */
// host controller: drives core fetch and data accesses into the memory map
module mem_host (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // software register port
  input  wire logic [3:0]  sw_addr,
  input  wire logic [7:0]  sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic      [7:0]  sw_rdata,
  // access port toward the memory map
  output logic      [19:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic             mem_fetch,
  output logic             mem_swap_sel,
  input  wire logic [7:0]  mem_rdata
);

  mem_host_pkg::state_t state_reg;
  mem_host_pkg::state_t state_next;

  // outputs straight from the state register
  assign sw_rdata     = state_reg.sw_rdata;
  assign mem_addr     = state_reg.req.addr;
  assign mem_wdata    = state_reg.req.wdata;
  assign mem_rd       = state_reg.req.rd;
  assign mem_wr       = state_reg.req.wr;
  assign mem_fetch    = state_reg.req.fetch;
  assign mem_swap_sel = state_reg.cfg[mem_host_pkg::CFG_SWAP_BIT];

  // next state: register port, address checks and the access sequencer
  always_comb begin
    logic [19:0] ram_lo;
    logic [19:0] target;
    logic [19:0] swap_add;
    logic        mirror_hit;
    logic        gpr_hit;
    logic        prog_hit;
    logic        refuse;
    logic        two_byte;
    logic        busy;
    ram_lo     = mem_host_pkg::RAM_LO_SMALL;
    target     = state_reg.addr;
    swap_add   = 20'h00000;
    mirror_hit = 1'b0;
    gpr_hit    = 1'b0;
    prog_hit   = 1'b0;
    refuse     = 1'b0;
    two_byte   = 1'b0;
    busy       = (state_reg.fsm != mem_host_pkg::S_IDLE);
    state_next = state_reg;
    state_next.sw_rdata = 8'h00;

    // ram base from the size strap in cfg
    if (state_reg.cfg[mem_host_pkg::CFG_LARGE_RAM_BIT]) begin
      ram_lo = mem_host_pkg::RAM_LO_LARGE;
    end
    // one swap select moves every table
    if (state_reg.cfg[mem_host_pkg::CFG_SWAP_BIT]) begin
      swap_add = mem_host_pkg::SWAP_OFFSET;
    end

    // target address of the first byte of each command
    case (state_reg.cmd)
      mem_host_pkg::CMD_VECTOR: begin
        // even entry inside the vector table
        target = mem_host_pkg::VEC_BASE + swap_add
               + {13'h0000, state_reg.addr[6:1], 1'b0};
        two_byte = 1'b1;
      end
      mem_host_pkg::CMD_RESET_VECTOR: begin
        // all reset causes share entry zero
        target   = mem_host_pkg::VEC_BASE + swap_add;
        two_byte = 1'b1;
      end
      mem_host_pkg::CMD_TABLE_CALL: begin
        // even entry inside the table-call table
        target = mem_host_pkg::TCALL_BASE + swap_add
               + {14'h0000, state_reg.addr[5:1], 1'b0};
        two_byte = 1'b1;
      end
      mem_host_pkg::CMD_OPTION: begin
        // four option bytes, swap copy when selected
        target = mem_host_pkg::OPT_BASE + swap_add
               + {18'h00000, state_reg.addr[1:0]};
      end
      mem_host_pkg::CMD_SECID: begin
        // ten security id bytes, swap copy when selected
        target = mem_host_pkg::SECID_BASE + swap_add
               + {16'h0000, state_reg.addr[3:0]};
      end
      default: begin
        target = state_reg.addr;
      end
    endcase

    mirror_hit = (target >= mem_host_pkg::MIRROR_LO)
               && (target > mem_host_pkg::EXT_PERIPH_HI)
               && (target < ram_lo);
    // register bank bytes at the top of ram
    gpr_hit = (target >= mem_host_pkg::GPR_LO)
            && (target <= mem_host_pkg::RAM_HI);
    // work area of self-programming is off limits
    prog_hit = state_reg.cfg[mem_host_pkg::CFG_SELFPROG_BIT]
             && (target >= mem_host_pkg::SELFPROG_LO)
             && (target <= mem_host_pkg::SELFPROG_HI);
    // library area on large ram parts too
    if (state_reg.cfg[mem_host_pkg::CFG_SELFPROG_BIT]
        && state_reg.cfg[mem_host_pkg::CFG_LARGE_RAM_BIT]
        && (target >= mem_host_pkg::LIB_LO)
        && (target <= mem_host_pkg::LIB_HI)) begin
      prog_hit = 1'b1;
    end

    // refusal per command
    case (state_reg.cmd)
      mem_host_pkg::CMD_READ: begin
        refuse = prog_hit;
      end
      mem_host_pkg::CMD_WRITE: begin
        // mirror area select must stay zero
        refuse = prog_hit || mirror_hit
               || ((target == mem_host_pkg::MIRROR_CTRL_ADDR)
                   && state_reg.wdata[mem_host_pkg::MIRROR_SELECT_BIT]);
      end
      mem_host_pkg::CMD_FETCH: begin
        // no fetch from mirror or register banks
        refuse = prog_hit || mirror_hit || gpr_hit;
      end
      mem_host_pkg::CMD_SECID: begin
        refuse = (state_reg.addr[3:0] >= mem_host_pkg::SECID_LEN);
      end
      default: begin
        refuse = 1'b0;
      end
    endcase

    // guard counter runs down on its own
    if (state_reg.guard != 4'h0) begin
      state_next.guard = state_reg.guard - 4'h1;
    end

    // register writes; request fields only change while idle
    if (sw_wr) begin
      case (sw_addr)
        mem_host_pkg::REG_CMD: begin
          // a command while busy is dropped
          if (!busy) begin
            state_next.cmd     = mem_host_pkg::cmd_t'(sw_wdata[2:0]);
            state_next.fsm     = mem_host_pkg::S_CHECK;
            state_next.done    = 1'b0;
            state_next.refused = 1'b0;
          end
        end
        mem_host_pkg::REG_ADDR_L: begin
          if (!busy) begin
            state_next.addr[7:0] = sw_wdata;
          end
        end
        mem_host_pkg::REG_ADDR_M: begin
          if (!busy) begin
            state_next.addr[15:8] = sw_wdata;
          end
        end
        mem_host_pkg::REG_ADDR_H: begin
          if (!busy) begin
            state_next.addr[19:16] = sw_wdata[3:0];
          end
        end
        mem_host_pkg::REG_WDATA: begin
          if (!busy) begin
            state_next.wdata = sw_wdata;
          end
        end
        mem_host_pkg::REG_CFG: begin
          if (!busy) begin
            state_next.cfg = sw_wdata[2:0];
          end
        end
        default: begin
          state_next.cfg = state_next.cfg;
        end
      endcase
    end

    // reads answer next cycle, unknown index reads 00
    if (sw_rd) begin
      case (sw_addr)
        mem_host_pkg::REG_CMD:     state_next.sw_rdata = {5'h00, state_reg.cmd};
        mem_host_pkg::REG_ADDR_L:  state_next.sw_rdata = state_reg.addr[7:0];
        mem_host_pkg::REG_ADDR_M:  state_next.sw_rdata = state_reg.addr[15:8];
        mem_host_pkg::REG_ADDR_H:
          state_next.sw_rdata = {4'h0, state_reg.addr[19:16]};
        mem_host_pkg::REG_WDATA:   state_next.sw_rdata = state_reg.wdata;
        mem_host_pkg::REG_CFG:     state_next.sw_rdata = {5'h00, state_reg.cfg};
        mem_host_pkg::REG_STATUS:
          state_next.sw_rdata = {4'h0, (state_reg.guard != 4'h0),
                                 state_reg.refused, state_reg.done, busy};
        mem_host_pkg::REG_RDATA_L: state_next.sw_rdata = state_reg.result[7:0];
        mem_host_pkg::REG_RDATA_M:
          state_next.sw_rdata = state_reg.result[15:8];
        mem_host_pkg::REG_RDATA_H:
          state_next.sw_rdata = {4'h0, state_reg.result[19:16]};
        default:                   state_next.sw_rdata = 8'h00;
      endcase
    end

    // access sequencer
    case (state_reg.fsm)
      mem_host_pkg::S_IDLE: begin
        state_next.req.rd    = 1'b0;
        state_next.req.wr    = 1'b0;
        state_next.req.fetch = 1'b0;
      end
      mem_host_pkg::S_CHECK: begin
        if (refuse) begin
          state_next.refused = 1'b1;
          state_next.done    = 1'b1;
          state_next.fsm     = mem_host_pkg::S_IDLE;
        end else if (mirror_hit && (state_reg.guard != 4'h0)) begin
          // hold mirror reads until the guard expires
          state_next.fsm = mem_host_pkg::S_CHECK;
        end else begin
          state_next.req.addr  = target;
          state_next.req.wdata = state_reg.wdata;
          state_next.req.wr    = (state_reg.cmd == mem_host_pkg::CMD_WRITE);
          state_next.req.fetch = (state_reg.cmd == mem_host_pkg::CMD_FETCH);
          state_next.req.rd    = !state_next.req.wr && !state_next.req.fetch;
          state_next.result    = 20'h00000;
          state_next.fsm       = mem_host_pkg::S_STROBE_LO;
          // writing mirror control arms the guard
          if (state_next.req.wr
              && (target == mem_host_pkg::MIRROR_CTRL_ADDR)) begin
            state_next.guard = mem_host_pkg::MIRROR_GUARD_CYCLES;
          end
        end
      end
      mem_host_pkg::S_STROBE_LO: begin
        state_next.req.rd    = 1'b0;
        state_next.req.wr    = 1'b0;
        state_next.req.fetch = 1'b0;
        if (state_reg.req.wr) begin
          state_next.done = 1'b1;
          state_next.fsm  = mem_host_pkg::S_IDLE;
        end else begin
          state_next.fsm = mem_host_pkg::S_CAP_LO;
        end
      end
      mem_host_pkg::S_CAP_LO: begin
        // low byte from the even address
        state_next.result[7:0] = mem_rdata;
        if (two_byte) begin
          state_next.req.addr = state_reg.req.addr + 20'h00001;
          state_next.req.rd   = 1'b1;
          state_next.fsm      = mem_host_pkg::S_STROBE_HI;
        end else begin
          state_next.done = 1'b1;
          state_next.fsm  = mem_host_pkg::S_IDLE;
        end
      end
      mem_host_pkg::S_STROBE_HI: begin
        state_next.req.rd = 1'b0;
        state_next.fsm    = mem_host_pkg::S_CAP_HI;
      end
      mem_host_pkg::S_CAP_HI: begin
        // high byte from the odd address
        state_next.result[15:8]  = mem_rdata;
        state_next.result[19:16] = 4'h0;
        state_next.done          = 1'b1;
        state_next.fsm           = mem_host_pkg::S_IDLE;
      end
      default: begin
        state_next.fsm = mem_host_pkg::S_IDLE;
      end
    endcase
  end

  // single state register; device mirror control also restarts at 00H
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg.fsm       <= mem_host_pkg::S_IDLE;
      state_reg.cmd       <= mem_host_pkg::CMD_READ;
      state_reg.addr      <= 20'h00000;
      state_reg.wdata     <= mem_host_pkg::MIRROR_CTRL_RESET;
      state_reg.cfg       <= mem_host_pkg::CFG_RESET;
      state_reg.done      <= 1'b0;
      state_reg.refused   <= 1'b0;
      state_reg.guard     <= 4'h0;
      state_reg.result    <= 20'h00000;
      state_reg.sw_rdata  <= 8'h00;
      state_reg.req.addr  <= 20'h00000;
      state_reg.req.wdata <= 8'h00;
      state_reg.req.rd    <= 1'b0;
      state_reg.req.wr    <= 1'b0;
      state_reg.req.fetch <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule // mem_host

/* File: mem_host_props.sv */
// concurrent checks on the host controller ports
module mem_host_props (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // software read path
  input wire logic        sw_rd,
  input wire logic [7:0]  sw_rdata,
  // access port toward the memory map
  input wire logic [19:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic        mem_fetch
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // mirror span between extended peripherals and the large ram base
  logic in_mirror;
  logic any_strobe;
  assign in_mirror  = mem_addr >= 20'hF0800 && mem_addr <= 20'hFEEFF;
  assign any_strobe = mem_rd | mem_wr | mem_fetch;

  sequence s_ctrl_write;
    mem_wr && mem_addr == 20'hFFFFE;
  endsequence

  a_fetch_not_mirror: assert property (mem_fetch |-> !in_mirror)
    else $error("fetch issued into mirror");
  a_write_not_mirror: assert property (mem_wr |-> !in_mirror)
    else $error("write issued into mirror");
  a_fetch_not_banks: assert property (mem_fetch |->
    !(mem_addr >= 20'hFFEE0 && mem_addr <= 20'hFFEFF))
    else $error("fetch issued into register banks");
  a_select_kept_zero: assert property (s_ctrl_write |-> !mem_wdata[0])
    else $error("mirror area select written as one");
  a_guard_after_ctrl: assert property (s_ctrl_write |=>
    (!(mem_rd && in_mirror))[*3])
    else $error("mirror read too soon after control write");
  a_strobes_exclusive: assert property ($onehot0({mem_rd, mem_wr, mem_fetch}))
    else $error("two memory strobes at once");
  a_answer_slot_free: assert property ((mem_rd || mem_fetch) |=> !any_strobe)
    else $error("strobe in the answer cycle");
  a_addr_holds: assert property (!any_strobe |-> $stable({mem_addr, mem_wdata}))
    else $error("address or data moved without a strobe");
  a_rdata_idle: assert property (!sw_rd |=> sw_rdata == 8'h00)
    else $error("read data outside its slot");
endmodule // mem_host_props

bind mem_host mem_host_props props (
  .clk_sys   (clk_sys),
  .rst       (rst),
  .sw_rd     (sw_rd),
  .sw_rdata  (sw_rdata),
  .mem_addr  (mem_addr),
  .mem_wdata (mem_wdata),
  .mem_rd    (mem_rd),
  .mem_wr    (mem_wr),
  .mem_fetch (mem_fetch)
);

/* File: device_model.sv */
// behavioural memory map of the device behind the host controller
module device_model #(
  parameter bit LARGE_RAM = 1'b1
) (
  // clock
  input  wire logic        clk_sys,
  // access port from the host
  input  wire logic [19:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic        mem_fetch,
  input  wire logic        mem_swap_sel,
  output logic      [7:0]  mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0]  ctrl_reg = 8'h00;
  logic [7:0]  ram [4096];
  logic [19:0] ram_lo;
  logic [11:0] ram_idx;
  logic [7:0]  val;
  assign ram_lo  = LARGE_RAM ? 20'hFEF00 : 20'hFF700;
  assign ram_idx = 12'(mem_addr - 20'hFEF00);

  function automatic logic [7:0] flash(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction

  // order of the tests is the decode precedence
  always_comb begin
    if (mem_addr < 20'h10000)
      val = flash(mem_addr[15:0]);
    else if (mem_addr >= 20'hFFF00)
      val = (mem_addr == 20'hFFFFE) ? ctrl_reg : 8'h00;
    else if (mem_addr >= ram_lo && mem_addr <= 20'hFFEFF)
      val = ram[ram_idx];
    else if (mem_addr <= 20'hF07FF && mem_addr >= 20'hF0000)
      val = 8'h00;
    else if (mem_addr >= 20'hF0000 && !mem_fetch)
      val = flash(mem_addr[15:0]);
    else
      val = 8'h00;
  end

  // answer one cycle on; stale data is scrambled so it never passes
  always @(posedge clk_sys) begin
    if (mem_rd || mem_fetch)
      mem_rdata <= val;
    else
      mem_rdata <= ~mem_rdata;
    // only the select bit is stored
    if (mem_wr && mem_addr == 20'hFFFFE)
      ctrl_reg <= {7'h00, mem_wdata[0]};
    else if (mem_wr && mem_addr >= ram_lo && mem_addr <= 20'hFFEFF)
      ram[ram_idx] <= mem_wdata;
  end
endmodule // device_model

/* File: testbench.sv */
// self-checking bench for the memory map host controller
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys;
  logic        rst;
  logic [3:0]  sw_addr;
  logic [7:0]  sw_wdata;
  logic        sw_wr;
  logic        sw_rd;
  logic [7:0]  sw_rdata;
  logic [19:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic        mem_rd;
  logic        mem_wr;
  logic        mem_fetch;
  logic        mem_swap_sel;
  logic [7:0]  mem_rdata;
  logic [19:0] res;
  logic [19:0] off;
  logic [7:0]  st;
  int          n_errors;
  int          compares;

  mem_host uut (.clk_sys(clk_sys), .rst(rst), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_fetch(mem_fetch), .mem_swap_sel(mem_swap_sel),
    .mem_rdata(mem_rdata));
  device_model dev (.clk_sys(clk_sys), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_fetch(mem_fetch), .mem_swap_sel(mem_swap_sel),
    .mem_rdata(mem_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // expected flash byte and little-endian pair built from it
  function automatic logic [7:0] fb(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction
  function automatic logic [19:0] pair(input logic [19:0] a);
    return {4'h0, fb(a + 20'h00001), fb(a)};
  endfunction

  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // an idle edge before each strobe keeps one driver step per signal
  task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask

  // issue one command, poll until done, then check status, and result unless refused or a write
  task automatic cmd(input mem_host_pkg::cmd_t c, input logic [19:0] a,
                     input logic [7:0] w, input logic [19:0] e, input int rf);
    logic [7:0] b;
    sw_write(mem_host_pkg::REG_ADDR_L, a[7:0]);
    sw_write(mem_host_pkg::REG_ADDR_M, a[15:8]);
    sw_write(mem_host_pkg::REG_ADDR_H, {4'h0, a[19:16]});
    sw_write(mem_host_pkg::REG_WDATA, w);
    sw_write(mem_host_pkg::REG_CMD, {5'h00, c});
    st = 8'h00;
    for (int k = 0; k < 40 && st[mem_host_pkg::ST_DONE_BIT] !== 1'b1; k++)
      sw_read(mem_host_pkg::REG_STATUS, st);
    chk("status", {18'h0, rf[0], 1'b1}, {18'h0,
      st[mem_host_pkg::ST_REFUSED_BIT], st[mem_host_pkg::ST_DONE_BIT]});
    if (rf == 0 && c != mem_host_pkg::CMD_WRITE) begin
      sw_read(mem_host_pkg::REG_RDATA_L, b);
      res[7:0] = b;
      sw_read(mem_host_pkg::REG_RDATA_M, b);
      res[15:8] = b;
      sw_read(mem_host_pkg::REG_RDATA_H, b);
      res[19:16] = b[3:0];
      chk("result", e, res);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // a full run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    report_and_stop;
  end

  initial begin
    rst = 1'b1;
    sw_addr = 4'h0;
    sw_wdata = 8'h00;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    n_errors = 0;
    compares = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    sw_read(4'hC, st);
    chk("unmapped", 20'h0, {12'h0, st});
    sw_read(mem_host_pkg::REG_STATUS, st);
    chk("idle status", 20'h0, {12'h0, st});
    for (int s = 0; s < 2; s++) begin
      off = s ? 20'h01000 : 20'h00000;
      sw_write(mem_host_pkg::REG_CFG, s ? 8'h01 : 8'h00);
      #1 chk("swap_sel", 20'(s), {19'h0, mem_swap_sel});
      cmd(mem_host_pkg::CMD_VECTOR, 20'h04, 8'h0, pair(off + 20'h04), 0);
      cmd(mem_host_pkg::CMD_VECTOR, 20'h7E, 8'h0, pair(off + 20'h7E), 0);
      cmd(mem_host_pkg::CMD_RESET_VECTOR, 20'h46, 8'h0, pair(off), 0);
      cmd(mem_host_pkg::CMD_TABLE_CALL, 20'h3E, 8'h0, pair(off + 20'hBE), 0);
      cmd(mem_host_pkg::CMD_OPTION, 20'h03, 8'h0,
          20'(fb(off + 20'hC3)), 0);
      cmd(mem_host_pkg::CMD_SECID, 20'h09, 8'h0,
          20'(fb(off + 20'hCD)), 0);
      cmd(mem_host_pkg::CMD_SECID, 20'h0A, 8'h0, 20'h0, 1);
    end
    sw_write(mem_host_pkg::REG_CFG, 8'h00);
    cmd(mem_host_pkg::CMD_READ, 20'hF1234, 8'h0, 20'(fb(20'h1234)), 0);
    cmd(mem_host_pkg::CMD_READ, 20'hF0100, 8'h0, 20'h0, 0);
    cmd(mem_host_pkg::CMD_READ, 20'hFFF10, 8'h0, 20'h0, 0);
    cmd(mem_host_pkg::CMD_READ, 20'hFFFFE, 8'h0, 20'h0, 0);
    cmd(mem_host_pkg::CMD_WRITE, 20'hFFFFE, 8'h01, 20'h0, 1);
    cmd(mem_host_pkg::CMD_WRITE, 20'hFFFFE, 8'h00, 20'h0, 0);
    // repeat the control write; guard must show while busy
    sw_write(mem_host_pkg::REG_CMD, {5'h00, mem_host_pkg::CMD_WRITE});
    sw_read(mem_host_pkg::REG_STATUS, st);
    chk("guard status", 20'h00009, {12'h0, st});
    cmd(mem_host_pkg::CMD_READ, 20'hF4321, 8'h0, 20'(fb(20'h4321)), 0);
    cmd(mem_host_pkg::CMD_WRITE, 20'hF4000, 8'h11, 20'h0, 1);
    cmd(mem_host_pkg::CMD_FETCH, 20'hF2000, 8'h0, 20'h0, 1);
    cmd(mem_host_pkg::CMD_FETCH, 20'hFFEE0, 8'h0, 20'h0, 1);
    cmd(mem_host_pkg::CMD_WRITE, 20'hFFEFF, 8'h3C, 20'h0, 0);
    cmd(mem_host_pkg::CMD_READ, 20'hFFEFF, 8'h0, 20'h3C, 0);
    cmd(mem_host_pkg::CMD_WRITE, 20'hFF700, 8'h5A, 20'h0, 0);
    cmd(mem_host_pkg::CMD_FETCH, 20'hFF700, 8'h0, 20'h5A, 0);
    sw_write(mem_host_pkg::REG_CFG, 8'h04);
    cmd(mem_host_pkg::CMD_WRITE, 20'hFEF00, 8'h96, 20'h0, 0);
    cmd(mem_host_pkg::CMD_READ, 20'hFEF00, 8'h0, 20'h96, 0);
    cmd(mem_host_pkg::CMD_WRITE, 20'hFF30A, 8'h69, 20'h0, 0);
    sw_write(mem_host_pkg::REG_CFG, 8'h06);
    cmd(mem_host_pkg::CMD_READ, 20'hFFE20, 8'h0, 20'h0, 1);
    cmd(mem_host_pkg::CMD_WRITE, 20'hFFEDF, 8'h1, 20'h0, 1);
    cmd(mem_host_pkg::CMD_READ, 20'hFF309, 8'h0, 20'h0, 1);
    cmd(mem_host_pkg::CMD_READ, 20'hFF30A, 8'h0, 20'h69, 0);
    report_and_stop;
  end
endmodule // testbench
